//--- shared/flash_cmd_pkg.sv
package flash_cmd_pkg;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_STATUS_READ     = 8'h05;
  localparam logic [7:0] OP_BLOCK_ERASE     = 8'hD8;
  localparam logic [7:0] OP_ARRAY_ERASE_A   = 8'h60;
  localparam logic [7:0] OP_ARRAY_ERASE_B   = 8'hC7;
  localparam logic [7:0] OP_DEEP_SLEEP      = 8'hB9;
  localparam logic [7:0] OP_WAKE_AND_ID     = 8'hAB;
  localparam logic [7:0] OP_MAKER_DEVICE_ID = 8'h90;
  localparam logic [7:0] OP_THREE_BYTE_ID   = 8'h9F;

  // ----------------------------------------------------------------
  // Frame lengths in received bits
  // ----------------------------------------------------------------
  localparam logic [5:0] BITS_OPCODE  = 6'h08;
  localparam logic [5:0] BITS_ADDRESS = 6'h20;
  localparam logic [5:0] BITS_NEVER   = 6'h3F;
  localparam logic [5:0] BITS_LAST_OP = 6'h07;

  // ----------------------------------------------------------------
  // Array layout and protection
  // ----------------------------------------------------------------
  localparam int          BLOCK_LSB   = 16;
  localparam int          BLOCK_MSB   = 20;
  localparam logic [5:0]  BLOCK_COUNT = 6'h20;
  localparam logic [2:0]  BP_ALL      = 3'h6;
  localparam logic [2:0]  BP_ONES     = 3'h7;
  localparam logic [2:0]  BP_ZEROS    = 3'h0;
  localparam int          BP_BOTTOM   = 3;

  // ----------------------------------------------------------------
  // Status byte and identification (ID values are arbitrary)
  // ----------------------------------------------------------------
  localparam int         STATUS_WIP_BIT = 0;
  localparam int         STATUS_WEL_BIT = 1;
  localparam logic [7:0] MAKER_ID       = 8'hA5;
  localparam logic [7:0] DEVICE_ID      = 8'h3C;
  localparam logic [7:0] MEMORY_TYPE    = 8'h40;
  localparam logic [7:0] CAPACITY_CODE  = 8'h15;

  // ----------------------------------------------------------------
  // Timing at 250 MHz
  // ----------------------------------------------------------------
  localparam longint unsigned CLK_PERIOD_PS         = 4000;
  localparam longint unsigned SLEEP_ENTRY_DELAY_NS  = 3000;
  localparam longint unsigned WAKE_DELAY_NS         = 3000;
  localparam longint unsigned WAKE_WITH_ID_DELAY_NS = 1800;
  localparam longint unsigned BLOCK_ERASE_TIME_MS   = 150;
  localparam longint unsigned ARRAY_ERASE_TIME_MS   = 8000;
  localparam logic [31:0] SLEEP_ENTRY_CYCLES =
    32'((SLEEP_ENTRY_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [31:0] WAKE_CYCLES =
    32'((WAKE_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [31:0] WAKE_WITH_ID_CYCLES =
    32'((WAKE_WITH_ID_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [31:0] BLOCK_ERASE_CYCLES =
    32'(BLOCK_ERASE_TIME_MS * 64'd1000000000 / CLK_PERIOD_PS);
  localparam logic [31:0] ARRAY_ERASE_CYCLES =
    32'(ARRAY_ERASE_TIME_MS * 64'd1000000000 / CLK_PERIOD_PS);

  // Internal cycle sequencer
  typedef enum logic [3:0] {
    ST_IDLE       = 4'h1,
    ST_ERASE      = 4'h2,
    ST_SLEEP_WAIT = 4'h4,
    ST_WAKE_WAIT  = 4'h8
  } op_state_t;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------

  // Whether a 64KB block is covered by the protect setting
  function automatic logic block_prot(input logic [4:0] bp,
                                      input logic       cmp,
                                      input logic [4:0] blk);
    logic [5:0] n;
    logic       hit;
    n   = 6'h00;
    hit = 1'b0;
    if (bp[2:0] >= BP_ALL) begin
      n = BLOCK_COUNT;
    end else if (bp[2:0] != BP_ZEROS) begin
      n = 6'h01 << (bp[2:0] - 3'h1);
    end
    // Top-down by default, bottom-up when the bottom bit is set
    if (bp[BP_BOTTOM]) begin
      hit = ({1'b0, blk} < n);
    end else begin
      hit = ({1'b0, blk} >= (BLOCK_COUNT - n));
    end
    return hit ^ cmp;
  endfunction

  // Chip erase only with nothing at all protected
  function automatic logic chip_free(input logic [4:0] bp, input logic cmp);
    return ((bp[2:0] == BP_ZEROS) && !cmp) ||
           ((bp[2:0] == BP_ONES) && cmp);
  endfunction

  // Whether an opcode is heard in the present device state
  function automatic logic heard(input logic [7:0] op,
                                 input logic       sleeping,
                                 input op_state_t  st);
    logic ok;
    ok = 1'b0;
    case (st)
      ST_IDLE: begin
        ok = sleeping ? (op == OP_WAKE_AND_ID) : 1'b1;
      end
      ST_ERASE: begin
        // Only status polling gets through a running erase
        ok = (op == OP_STATUS_READ);
      end
      default: begin
        ok = 1'b0;
      end
    endcase
    return ok;
  endfunction

  // Received bit count at which output begins
  function automatic logic [5:0] out_start(input logic [7:0] op);
    logic [5:0] n;
    case (op)
      OP_STATUS_READ:     n = BITS_OPCODE;
      OP_THREE_BYTE_ID:   n = BITS_OPCODE;
      OP_WAKE_AND_ID:     n = BITS_ADDRESS;
      OP_MAKER_DEVICE_ID: n = BITS_ADDRESS;
      default:            n = BITS_NEVER;
    endcase
    return n;
  endfunction

endpackage

//--- rtl/cycle_timer.sv
`timescale 1ns/10ps
`default_nettype none
module cycle_timer (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // Load a count; done pulses after that many cycles
  input  wire logic        load_in,
  input  wire logic [31:0] count_in,
  output logic             busy_out,
  output logic             done_out
);

  logic [31:0] remain;  // Cycles still to run

  // ----------------------------------------------------------------
  // Down counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      remain   <= 32'h0000_0000;
      done_out <= 1'b0;
    end else if (load_in) begin
      remain   <= count_in;
      done_out <= 1'b0;
    end else begin
      // Done rises in the cycle the count runs out
      done_out <= (remain == 32'h0000_0001);
      if (remain != 32'h0000_0000) begin
        remain <= remain - 32'h0000_0001;
      end
    end
  end

  assign busy_out = (remain != 32'h0000_0000);

endmodule // cycle_timer
`default_nettype wire

//--- rtl/flash_cmd_core.sv
// Summary of operation
// - Block erase D8H needs write latch set
// - Any address erases its whole block
// - Block erase valid only after 32 bits
// - Erase sets busy, clears write latch
// - Protected block is never erased
// - Chip erase 60H/C7H needs write latch
// - Chip erase valid only after 8 bits
// - Chip erase only when nothing protected
// - Deep sleep ignores all but wake
// - Sleep after delay, exact 8-bit frame
// - Sleep command refused while busy
// - Deselected and idle means standby
// - Power-up comes up in standby
// - Wake opcode alone releases, then delay
// - Wake with dummies repeats device ID
// - ID-form wake uses second delay
// - Wake command ignored while busy
// - 90H gives maker/device, address swaps
// - 9FH gives maker, type, capacity
// - 9FH not decoded while busy
// - Deselect ends ID output, standby
`timescale 1ns/10ps
`default_nettype none
module flash_cmd_core #(
  parameter logic [31:0] BLOCK_ERASE_CYCLES = flash_cmd_pkg::BLOCK_ERASE_CYCLES,
  parameter logic [31:0] ARRAY_ERASE_CYCLES = flash_cmd_pkg::ARRAY_ERASE_CYCLES
) (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // Serial port from the host
  input  wire logic       cs_n_in,
  input  wire logic       sclk_in,
  input  wire logic       si_in,
  output logic            so_out,
  output logic            so_oe_n_out,
  // Protection settings
  input  wire logic [4:0] block_protect_bits_in,
  input  wire logic       protect_complement_in,
  // High performance entry from the mode command logic
  input  wire logic       high_perf_enter_in,
  // Status
  output logic            write_in_progress_out,
  output logic            write_enable_latch_out,
  output logic            deep_sleep_out,
  output logic            high_perf_state_out,
  output logic            standby_out,
  // Erase request to the array
  output logic            erase_start_out,
  output logic            erase_whole_chip_out,
  output logic [4:0]      erase_block_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  flash_cmd_pkg::op_state_t op_state;  // Internal cycle sequencer
  logic        sclk_prev;              // Clock level last cycle
  logic        cs_prev;                // Select level last cycle
  logic [7:0]  shift_in;               // Receive shifter
  logic [5:0]  bit_cnt;                // Bits received, saturating
  logic [7:0]  opcode;                 // Latched opcode
  logic [23:0] addr;                   // Latched address or dummies
  logic [7:0]  tx;                     // Transmit shifter
  logic [2:0]  tx_left;                // Bits left in tx
  logic [1:0]  byte_idx;               // Next output byte index
  logic        write_enable_latch;                    // Write enable latch
  logic        sleeping;               // Deep sleep
  logic        high_perf_state;                    // High performance state
  logic        timer_load;             // Start a timed phase
  logic [31:0] timer_count;            // Its length
  logic        timer_busy;             // Timed phase running
  logic        timer_done;             // Timed phase ended
  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_rise;
  logic        cmd_ok;
  logic        is_erase;
  logic        write_in_progress;
  logic        tx_on;
  logic [7:0]  next_byte;              // Byte for the next output slot

  // ----------------------------------------------------------------
  // Pin edge detection
  // ----------------------------------------------------------------
  // Pins are synchronous, so a one-cycle history suffices
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sclk_prev <= 1'b0;
      cs_prev   <= 1'b1;
    end else begin
      sclk_prev <= sclk_in;
      cs_prev   <= cs_n_in;
    end
  end

  assign sclk_rise = !cs_n_in && sclk_in && !sclk_prev;
  assign sclk_fall = !cs_n_in && !sclk_in && sclk_prev;
  assign cs_rise   = cs_n_in && !cs_prev;
  assign write_in_progress       = (op_state == flash_cmd_pkg::ST_ERASE);
  // Only judged once a full opcode is in
  assign cmd_ok    = (bit_cnt >= flash_cmd_pkg::BITS_OPCODE) &&
                     flash_cmd_pkg::heard(opcode, sleeping, op_state);
  assign is_erase  = (opcode == flash_cmd_pkg::OP_ARRAY_ERASE_A) ||
                     (opcode == flash_cmd_pkg::OP_ARRAY_ERASE_B);
  assign tx_on     = cmd_ok && (bit_cnt >= flash_cmd_pkg::out_start(opcode)) &&
                     (flash_cmd_pkg::out_start(opcode) != flash_cmd_pkg::BITS_NEVER);

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      shift_in <= 8'h00;
      bit_cnt  <= 6'h00;
      opcode   <= 8'h00;
      addr     <= 24'h00_0000;
    end else if (cs_n_in) begin
      // Each frame counts from zero
      bit_cnt <= 6'h00;
    end else if (sclk_rise) begin
      shift_in <= {shift_in[6:0], si_in};
      if (bit_cnt != flash_cmd_pkg::BITS_NEVER) begin
        bit_cnt <= bit_cnt + 6'h01;
      end
      if (bit_cnt == flash_cmd_pkg::BITS_LAST_OP) begin
        opcode <= {shift_in[6:0], si_in};
      end else if ((bit_cnt >= flash_cmd_pkg::BITS_OPCODE) &&
                   (bit_cnt < flash_cmd_pkg::BITS_ADDRESS)) begin
        addr <= {addr[22:0], si_in};
      end
    end
  end

  // ----------------------------------------------------------------
  // Command execution at deselect
  // ----------------------------------------------------------------
  // A frame counts only if it ends on its exact last bit; the ID-form wake takes 32 bits or more
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      op_state             <= flash_cmd_pkg::ST_IDLE;
      write_enable_latch                  <= 1'b0;
      sleeping             <= 1'b0;
      high_perf_state                  <= 1'b0;
      timer_load           <= 1'b0;
      timer_count          <= 32'h0000_0000;
      erase_start_out      <= 1'b0;
      erase_whole_chip_out <= 1'b0;
      erase_block_out      <= 5'h00;
    end else begin
      timer_load      <= 1'b0;
      erase_start_out <= 1'b0;
      if (timer_done) begin
        // Timed phase over: erase ends busy, sleep wait enters sleep
        if (op_state == flash_cmd_pkg::ST_SLEEP_WAIT) begin
          sleeping <= 1'b1;
        end
        op_state <= flash_cmd_pkg::ST_IDLE;
      end else if (cs_rise && cmd_ok) begin
        case (opcode)
          flash_cmd_pkg::OP_WRITE_LATCH_SET: begin
            if (bit_cnt == flash_cmd_pkg::BITS_OPCODE) begin
              write_enable_latch <= 1'b1;
            end
          end
          flash_cmd_pkg::OP_BLOCK_ERASE: begin
            // Low address bits ignored: the whole block goes
            if ((bit_cnt == flash_cmd_pkg::BITS_ADDRESS) && write_enable_latch &&
                !flash_cmd_pkg::block_prot(block_protect_bits_in, protect_complement_in,
                            addr[flash_cmd_pkg::BLOCK_MSB:
                                 flash_cmd_pkg::BLOCK_LSB])) begin
              write_enable_latch                  <= 1'b0;
              op_state             <= flash_cmd_pkg::ST_ERASE;
              timer_load           <= 1'b1;
              timer_count          <= BLOCK_ERASE_CYCLES;
              erase_start_out      <= 1'b1;
              erase_whole_chip_out <= 1'b0;
              erase_block_out      <= addr[flash_cmd_pkg::BLOCK_MSB:
                                           flash_cmd_pkg::BLOCK_LSB];
            end
          end
          flash_cmd_pkg::OP_DEEP_SLEEP: begin
            // Heard only when idle, so a running erase is untouched
            if (bit_cnt == flash_cmd_pkg::BITS_OPCODE) begin
              high_perf_state         <= 1'b0;
              op_state    <= flash_cmd_pkg::ST_SLEEP_WAIT;
              timer_load  <= 1'b1;
              timer_count <= flash_cmd_pkg::SLEEP_ENTRY_CYCLES;
            end
          end
          flash_cmd_pkg::OP_WAKE_AND_ID: begin
            if (bit_cnt == flash_cmd_pkg::BITS_OPCODE) begin
              high_perf_state <= 1'b0;
              if (sleeping) begin
                sleeping    <= 1'b0;
                op_state    <= flash_cmd_pkg::ST_WAKE_WAIT;
                timer_load  <= 1'b1;
                timer_count <= flash_cmd_pkg::WAKE_CYCLES;
              end
            end else if ((bit_cnt >= flash_cmd_pkg::BITS_ADDRESS) &&
                         sleeping) begin
              sleeping    <= 1'b0;
              op_state    <= flash_cmd_pkg::ST_WAKE_WAIT;
              timer_load  <= 1'b1;
              timer_count <= flash_cmd_pkg::WAKE_WITH_ID_CYCLES;
            end
          end
          default: begin
            // Both chip erase opcodes land here
            if (is_erase && (bit_cnt == flash_cmd_pkg::BITS_OPCODE) &&
                write_enable_latch && flash_cmd_pkg::chip_free(block_protect_bits_in,
                                 protect_complement_in)) begin
              write_enable_latch                  <= 1'b0;
              op_state             <= flash_cmd_pkg::ST_ERASE;
              timer_load           <= 1'b1;
              timer_count          <= ARRAY_ERASE_CYCLES;
              erase_start_out      <= 1'b1;
              erase_whole_chip_out <= 1'b1;
            end
          end
        endcase
      end
      // Mode entry last, so it wins over a clear in the same cycle
      if (high_perf_enter_in) begin
        high_perf_state <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Shared timer for erase, sleep entry and wake
  // ----------------------------------------------------------------
  cycle_timer u_timer (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .load_in  (timer_load),
    .count_in (timer_count),
    .busy_out (timer_busy),
    .done_out (timer_done)
  );

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  // Bits leave on falling clock; bytes wrap so ID reads repeat
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      so_out      <= 1'b0;
      so_oe_n_out <= 1'b1;
      tx          <= 8'h00;
      tx_left     <= 3'h0;
      byte_idx    <= 2'h0;
    end else if (cs_n_in) begin
      // Deselect ends any output and releases the pin
      so_oe_n_out <= 1'b1;
      tx_left     <= 3'h0;
      byte_idx    <= 2'h0;
    end else if (sclk_fall && tx_on) begin
      so_oe_n_out <= 1'b0;
      if (tx_left == 3'h0) begin
        so_out  <= next_byte[7];
        tx      <= {next_byte[6:0], 1'b0};
        tx_left <= 3'h7;
        if ((opcode == flash_cmd_pkg::OP_THREE_BYTE_ID) &&
            (byte_idx == 2'h2)) begin
          byte_idx <= 2'h0;
        end else begin
          byte_idx <= byte_idx + 2'h1;
        end
      end else begin
        so_out  <= tx[7];
        tx      <= {tx[6:0], 1'b0};
        tx_left <= tx_left - 3'h1;
      end
    end
  end

  // Byte selected for the next output slot
  always_comb begin
    next_byte = 8'h00;
    case (opcode)
      flash_cmd_pkg::OP_WAKE_AND_ID: begin
        next_byte = flash_cmd_pkg::DEVICE_ID;
      end
      flash_cmd_pkg::OP_MAKER_DEVICE_ID: begin
        // Address bit zero swaps the pair
        next_byte = (byte_idx[0] ^ addr[0]) ? flash_cmd_pkg::DEVICE_ID
                                            : flash_cmd_pkg::MAKER_ID;
      end
      flash_cmd_pkg::OP_THREE_BYTE_ID: begin
        if (byte_idx == 2'h0) begin
          next_byte = flash_cmd_pkg::MAKER_ID;
        end else if (byte_idx == 2'h1) begin
          next_byte = flash_cmd_pkg::MEMORY_TYPE;
        end else begin
          next_byte = flash_cmd_pkg::CAPACITY_CODE;
        end
      end
      flash_cmd_pkg::OP_STATUS_READ: begin
        next_byte[flash_cmd_pkg::STATUS_WIP_BIT] = write_in_progress;
        next_byte[flash_cmd_pkg::STATUS_WEL_BIT] = write_enable_latch;
      end
      default: begin
        next_byte = 8'h00;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------
  assign write_in_progress_out  = write_in_progress;
  assign write_enable_latch_out = write_enable_latch;
  assign deep_sleep_out         = sleeping;
  assign high_perf_state_out    = high_perf_state;
  assign standby_out = cs_n_in && !timer_busy && !sleeping &&
                       (op_state == flash_cmd_pkg::ST_IDLE);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  erase_needs_latch_a: assert property (erase_start_out |-> $past(write_enable_latch))
    else $error("erase started without write latch");
  block_frame_a: assert property (erase_start_out && !erase_whole_chip_out
      |-> $past(bit_cnt) == flash_cmd_pkg::BITS_ADDRESS)
    else $error("block erase frame length wrong");
  erase_busy_a: assert property (erase_start_out
      |-> write_in_progress && !write_enable_latch ##1 write_in_progress [*4])
    else $error("erase not busy or latch still set");
  block_protect_a: assert property (erase_start_out && !erase_whole_chip_out
      |-> !flash_cmd_pkg::block_prot(block_protect_bits_in, protect_complement_in,
                      erase_block_out))
    else $error("protected block erased");
  chip_protect_a: assert property (erase_start_out && erase_whole_chip_out
      |-> flash_cmd_pkg::chip_free(block_protect_bits_in, protect_complement_in)
          && $past(bit_cnt) == flash_cmd_pkg::BITS_OPCODE)
    else $error("chip erase while protected or bad frame");
  sleep_ignores_a: assert property (sleeping |-> !erase_start_out)
    else $error("erase started in deep sleep");
  sleep_delay_a: assert property ($rose(sleeping)
      |-> $past(op_state) == flash_cmd_pkg::ST_SLEEP_WAIT)
    else $error("sleep entered without delay");
  busy_no_sleep_a: assert property (write_in_progress && cs_rise
      |=> op_state != flash_cmd_pkg::ST_SLEEP_WAIT)
    else $error("sleep accepted while busy");
  busy_output_a: assert property (write_in_progress && !so_oe_n_out
      |-> opcode == flash_cmd_pkg::OP_STATUS_READ)
    else $error("non-status output while busy");
  deselect_ends_a: assert property (cs_n_in |=> so_oe_n_out)
    else $error("output still driven after deselect");

  block_erase_c: cover property (erase_start_out && !erase_whole_chip_out);
  chip_erase_c: cover property (erase_start_out && erase_whole_chip_out);
  sleep_wake_c: cover property ($fell(sleeping));
  id_out_c: cover property (!so_oe_n_out &&
                            opcode == flash_cmd_pkg::OP_THREE_BYTE_ID);

endmodule // flash_cmd_core
`default_nettype wire

//--- sim/spi_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
  // Serial link
  input  wire logic  clk_in,
  input  wire logic  so_in,
  input  wire logic  so_oe_n_in,
  output logic       cs_n_out = 1'h1,
  output logic       sclk_out = 1'h0,
  output logic       si_out = 1'h0,
  // Bytes read back
  output logic       rx_valid_out = 1'h0,
  output logic [7:0] rx_byte_out
);
  // Clock idles low; each level is held 3 clocks, above the 2-clock minimum
  task automatic half(input logic s);
    sclk_out = s;
    repeat (3) @(posedge clk_in);
    #1;
  endtask
  // Opcode, nb address bits, then nr bytes taken at the rising clock
  task automatic frame(input logic [7:0] op, input logic [23:0] a, input int nb, input int nr);
    logic [31:0] w;
    w = {op, a};
    // Start every frame just after an edge, whatever the caller did
    @(posedge clk_in) #1;
    cs_n_out = 1'h0;
    for (int i = 0; i < 8 + nb + 8 * nr; i++) begin
      si_out = (i < 8 + nb) ? w[31 - i] : ~si_out;
      half(1'h0);
      half(1'h1);
      // A released line reads as the inverse, so a missing drive shows
      rx_byte_out = {rx_byte_out[6:0], so_oe_n_in ? ~so_in : so_in};
      if (i >= 8 + nb && (i - nb) % 8 == 7) begin
        rx_valid_out = 1'h1;
        @(posedge clk_in);
        #1 rx_valid_out = 1'h0;
      end
    end
    half(1'h0);
    cs_n_out = 1'h1;
    si_out = ~si_out;
    repeat (3) @(posedge clk_in);
    #1;
  endtask
endmodule // spi_host_model
`default_nettype wire

//--- sim/spi_flash_erase_power_id_cmds_tb.sv
`timescale 1ns/10ps
`default_nettype none
module spi_flash_erase_power_id_cmds_tb;
  logic clk_in = 1'h0, rst_n_in = 1'h0, cs_n_in, sclk_in, si_in, so_out, so_oe_n_out;
  logic high_perf_enter_in = 1'h0, protect_complement_in = 1'h0, probe = 1'h0, rx_valid;
  logic [4:0] block_protect_bits_in = 5'h00, erase_block_out;
  logic write_in_progress_out, write_enable_latch_out, deep_sleep_out, high_perf_state_out;
  logic standby_out, erase_start_out, erase_whole_chip_out;
  logic [7:0] rx_byte, got;
  logic [15:0] e, exp_q[$];
  logic [23:0] addr;
  int mismatches = 0, total_checks = 0;
  always #2 clk_in = ~clk_in;
  flash_cmd_core #(.BLOCK_ERASE_CYCLES(32'h190), .ARRAY_ERASE_CYCLES(32'h258)) i_flash_cmd_core (.*);
  spi_host_model i_spi_host_model (.clk_in(clk_in), .so_in(so_out), .so_oe_n_in(so_oe_n_out),
    .cs_n_out(cs_n_in),
    .sclk_out(sclk_in), .si_out(si_in), .rx_valid_out(rx_valid), .rx_byte_out(rx_byte));
  // Oldest note against each byte read, erase start or status probe
  always @(posedge clk_in)
    if (rx_valid || erase_start_out || probe) begin
      got = rx_valid ? rx_byte : erase_start_out ? {2'h0, erase_whole_chip_out, erase_block_out}
        : {3'h0, deep_sleep_out, high_perf_state_out, write_in_progress_out,
           write_enable_latch_out, standby_out};
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hFF5A;
      total_checks++;
      if ((got & e[15:8]) !== (e[7:0] & e[15:8])) begin
        mismatches++;
        $display("CHECK FAILED result expected %h seen %h", e[7:0], got);
      end
    end
  task automatic note(input logic [15:0] v); exp_q.push_back(v); endtask
  task automatic op(input logic [7:0] c, input logic [23:0] a = 24'h0, input int nb = 0);
    i_spi_host_model.frame(c, a, nb, 0);
  endtask
  // Mask 03: only the busy and latch bits of the status byte are known
  task automatic rd(input logic [7:0] v);
    note({8'h03, v});
    i_spi_host_model.frame(8'h05, 24'h0, 0, 1);
  endtask
  task automatic st(input logic [4:0] v);
    note({8'h1F, 3'h0, v});
    @(posedge clk_in);
    #1 probe = 1'h1;
    @(posedge clk_in);
    #1 probe = 1'h0;
  endtask
  task automatic idr(input logic [7:0] c, input logic [23:0] a, input int nb,
                     input logic [31:0] v, input int nr);
    for (int j = 0; j < nr; j++) note({8'hFF, v[31 - 8 * j -: 8]});
    i_spi_host_model.frame(c, a, nb, nr);
  endtask
  // Bounded wait for end of erase or for deep sleep
  task automatic wt(input logic slp);
    int n;
    for (n = 0; n < 900 && (slp ? deep_sleep_out !== 1'h1 : write_in_progress_out !== 1'h0); n++)
      @(posedge clk_in) #1;
    if (n == 900) begin
      mismatches++;
      finish_test();
    end
  endtask
  task automatic finish_test;
    mismatches += exp_q.size();
    $display("total_checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    void'($urandom(56173));
    repeat (4) @(posedge clk_in);
    #1 rst_n_in = 1'h1;
    st(5'h01);
    op(8'h06);
    rd(8'h02);
    addr = 24'($urandom);
    note({8'h3F, 3'h0, addr[20:16]});
    op(8'hD8, addr, 24);
    rd(8'h01);
    op(8'hB9);
    op(8'h9F);
    wt(1'h0);
    repeat (800) @(posedge clk_in);
    rd(8'h00);
    st(5'h01);
    op(8'hD8, addr, 24);
    rd(8'h00);
    op(8'h06);
    op(8'hD8, addr, 23);
    rd(8'h02);
    // Both chip erase codes, open, partly and fully protected settings
    for (int k = 0; k < 4; k++) begin
      block_protect_bits_in = (k == 0) ? 5'h00 : (k == 2) ? 5'h01 : 5'h07;
      protect_complement_in = (k == 1);
      op(8'h06);
      if (k < 2) note(16'h2020);
      op(k[0] ? 8'hC7 : 8'h60);
      rd(k < 2 ? 8'h01 : 8'h02);
      if (k == 0) op(8'hAB, 24'h0, 24);
      wt(1'h0);
    end
    block_protect_bits_in = 5'h01;
    protect_complement_in = 1'h0;
    op(8'hD8, {8'h1F, addr[15:0]}, 24);
    rd(8'h02);
    note(16'h3F00);
    op(8'hD8, {8'h00, addr[15:0]}, 24);
    wt(1'h0);
    idr(8'h9F, 24'h0, 0, 32'hA54015A5, 4);
    idr(8'h90, 24'h0, 24, 32'hA53C0000, 2);
    idr(8'h90, 24'h1, 24, 32'h3CA50000, 2);
    idr(8'hAB, 24'h0, 24, 32'h3C3C3C00, 3);
    repeat (460) @(posedge clk_in);
    idr(8'h9F, 24'h0, 0, 32'hA5000000, 1);
    st(5'h01);
    high_perf_enter_in = 1'h1;
    @(posedge clk_in);
    #1 high_perf_enter_in = 1'h0;
    st(5'h09);
    op(8'hAB);
    repeat (760) @(posedge clk_in);
    st(5'h01);
    op(8'hB9);
    st(5'h00);
    wt(1'h1);
    st(5'h10);
    op(8'h06);
    op(8'hAB);
    repeat (760) @(posedge clk_in);
    rd(8'h00);
    op(8'hB9);
    wt(1'h1);
    idr(8'hAB, 24'h0, 24, 32'h3C000000, 1);
    st(5'h00);
    repeat (460) @(posedge clk_in);
    st(5'h01);
    finish_test();
  end
endmodule // spi_flash_erase_power_id_cmds_tb
`default_nettype wire
